// File: rtl/flash_parallel_program_port.sv
// Device side of the handshaked parallel flash programming port
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_parallel_program_port #(
  parameter int DATA_W       = 16,
  parameter int FLASH_WORDS  = 1024,
  parameter int PAGE_WORDS   = 32,
  parameter int REGION_PAGES = 4,
  parameter int PROG_CYCLES  = fpp_pkg::PROG_CYCLES_DEFAULT,
  localparam int AW      = $clog2(FLASH_WORDS),
  localparam int OW      = $clog2(PAGE_WORDS),
  localparam int REGIONS = FLASH_WORDS / (PAGE_WORDS * REGION_PAGES)
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Programming pins
  input  wire logic              command_strobe_n,
  input  wire logic              output_enable_n,
  input  wire logic [3:0]        phaseSelect,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic                   dataOe_n,
  output logic                   ready,
  output logic                   data_valid_n,
  // Register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdData
);
  typedef enum logic [3:0] {
    S_IDLE, S_LATCH, S_EXEC, S_FLUSH_WAIT, S_RD_WAIT_OE, S_RD_DRIVE,
    S_RD_VALID, S_RD_WAIT_OE_HI, S_RD_RELEASE, S_WAIT_CMD_HI
  } state_e;

  if (!(DATA_W == 8 || DATA_W == 16) || FLASH_WORDS < 2 * PAGE_WORDS
      || (1 << AW) != FLASH_WORDS || (1 << OW) != PAGE_WORDS
      || AW > fpp_pkg::ADDR_BITS) begin : g_bad
    $error("flash_parallel_program_port: unsupported parameters");
  end

  state_e                       state_r;
  logic                         ready_r;
  logic                         validN_r;
  logic                         oeN_r;
  logic [DATA_W-1:0]            dout_r;
  logic [3:0]                   mode_r;
  logic [DATA_W-1:0]            data_r;
  logic [15:0]                  cmd_r;
  logic [fpp_pkg::ADDR_BITS-1:0] addr_r;
  logic [AW-OW-1:0]             bufPage_r;
  logic                         bufErase_r;
  logic                         bufLock_r;
  logic                         enable_r;
  logic [31:0]                  rdData_r;
  logic                         strobeSyncN;
  logic                         oeSyncN;
  logic [DATA_W-1:0]            flashWord;
  logic                         flushBusy;
  logic                         bufDirty;
  logic [REGIONS-1:0]           lockBits;

  ////////////////////////////////////////////////////////////////////
  // Synchronisers
  sync_2ff #(.W(2), .RST_VAL(1'b1)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({command_strobe_n, output_enable_n}),
    .syncOut ({strobeSyncN, oeSyncN})
  );

  ////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic [fpp_pkg::ADDR_BITS-1:0] load_addr(
    input logic [fpp_pkg::ADDR_BITS-1:0] cur,
    input logic [3:0]                    phase,
    input logic [DATA_W-1:0]             val
  );
    logic [fpp_pkg::ADDR_BITS-1:0] res;
    res = cur;
    for (int b = 0; b < fpp_pkg::ADDR_BITS; b++) begin
      if (b / DATA_W == int'(phase)) begin
        res[b] = val[b % DATA_W];
      end
    end
    return res;
  endfunction

  wire logic isCmdPhase  = (mode_r == fpp_pkg::PH_COMMAND);
  wire logic isAddrPhase = (mode_r >= fpp_pkg::PH_ADDRESS_PHASE_ZERO) && (mode_r <= fpp_pkg::PH_ADDRESS_PHASE_THREE);
  wire logic isDataPhase = (mode_r == fpp_pkg::PH_DATA);
  wire logic isRead      = (cmd_r == fpp_pkg::CMD_READ);
  wire logic isErase     = (cmd_r == fpp_pkg::CMD_ERASE_WRITE)
                        || (cmd_r == fpp_pkg::CMD_ERASE_WRITE_LOCK);
  wire logic isLock      = (cmd_r == fpp_pkg::CMD_WRITE_LOCK)
                        || (cmd_r == fpp_pkg::CMD_ERASE_WRITE_LOCK);
  wire logic isWrite     = isErase || isLock || (cmd_r == fpp_pkg::CMD_WRITE_PAGE);
  wire logic [AW-1:0]    wordAddr  = addr_r[AW-1:0];
  wire logic [AW-OW-1:0] wordPage  = wordAddr[AW-1:OW];
  wire logic             otherPage = (wordPage != bufPage_r);
  wire logic needFlush = bufDirty && (isCmdPhase
                      || (isDataPhase && (isRead || otherPage)));
  wire logic execNow   = (state_r == S_EXEC) && !needFlush && !flushBusy;
  wire logic flushReq  = (state_r == S_EXEC) && needFlush && !flushBusy;
  wire logic bufWe     = execNow && isDataPhase && isWrite;
  wire logic [15:0] dataExt = 16'(data_r);
  wire logic [3:0]  addrPhase = mode_r - fpp_pkg::PH_ADDRESS_PHASE_ZERO;
  wire logic regSelCtrl = (regAddr == fpp_pkg::REG_CTRL);
  wire logic [31:0] statusWord = (32'(lockBits) << fpp_pkg::STAT_LOCK_LSB)
                               | (32'(bufDirty) << fpp_pkg::STAT_DIRTY)
                               | (32'(flushBusy) << fpp_pkg::STAT_BUSY)
                               | (32'(ready_r) << fpp_pkg::STAT_READY);
  wire logic [31:0] regReadMux =
      (regAddr == fpp_pkg::REG_CTRL)    ? (32'(enable_r) << fpp_pkg::CTRL_ENABLE) :
      (regAddr == fpp_pkg::REG_STATUS)  ? statusWord :
      (regAddr == fpp_pkg::REG_COMMAND) ? 32'(cmd_r) :
      (regAddr == fpp_pkg::REG_ADDRESS) ? addr_r : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // Flash store
  flash_page_store #(
    .W            (DATA_W),
    .FLASH_WORDS  (FLASH_WORDS),
    .PAGE_WORDS   (PAGE_WORDS),
    .REGION_PAGES (REGION_PAGES),
    .PROG_CYCLES  (PROG_CYCLES)
  ) u_store (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .rdAddr     (wordAddr),
    .rdData     (flashWord),
    .bufWe      (bufWe),
    .bufOffset  (wordAddr[OW-1:0]),
    .bufData    (data_r),
    .flushReq   (flushReq),
    .flushPage  (bufPage_r),
    .flushErase (bufErase_r),
    .flushLock  (bufLock_r),
    .busy       (flushBusy),
    .dirty      (bufDirty),
    .lockBits   (lockBits)
  );

  ////////////////////////////////////////////////////////////////////
  // Handshake sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r    <= S_IDLE;
      ready_r    <= 1'b0;
      validN_r   <= 1'b1;
      oeN_r      <= 1'b1;
      dout_r     <= '0;
      mode_r     <= '0;
      data_r     <= '0;
      cmd_r      <= fpp_pkg::CMD_RESET;
      addr_r     <= '0;
      bufPage_r  <= '0;
      bufErase_r <= 1'b0;
      bufLock_r  <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          ready_r <= enable_r;
          if (enable_r && ready_r && !strobeSyncN) begin
            mode_r  <= phaseSelect;
            data_r  <= dataIn;
            state_r <= S_LATCH;
          end
        end
        S_LATCH: begin
          ready_r <= 1'b0;
          state_r <= S_EXEC;
        end
        S_EXEC: begin
          if (flushReq) begin
            state_r <= S_FLUSH_WAIT;
          end else if (execNow) begin
            state_r <= S_WAIT_CMD_HI;
            if (isCmdPhase) begin
              cmd_r <= dataExt;
            end else if (isAddrPhase) begin
              addr_r <= load_addr(addr_r, addrPhase, data_r);
            end else if (isDataPhase && isRead) begin
              state_r <= S_RD_WAIT_OE;
            end else if (bufWe) begin
              bufPage_r  <= wordPage;
              bufErase_r <= isErase;
              bufLock_r  <= isLock;
              addr_r     <= addr_r + 1'b1;
            end
          end
        end
        S_FLUSH_WAIT: begin
          if (!bufDirty) begin
            state_r <= S_EXEC;
          end
        end
        S_RD_WAIT_OE: begin
          if (!oeSyncN) begin
            state_r <= S_RD_DRIVE;
          end
        end
        S_RD_DRIVE: begin
          dout_r  <= flashWord;
          oeN_r   <= 1'b0;
          state_r <= S_RD_VALID;
        end
        S_RD_VALID: begin
          validN_r <= 1'b0;
          state_r  <= S_RD_WAIT_OE_HI;
        end
        S_RD_WAIT_OE_HI: begin
          if (oeSyncN) begin
            oeN_r   <= 1'b1;
            addr_r  <= addr_r + 1'b1;
            state_r <= S_RD_RELEASE;
          end
        end
        S_RD_RELEASE: begin
          validN_r <= 1'b1;
          state_r  <= S_WAIT_CMD_HI;
        end
        S_WAIT_CMD_HI: begin
          if (strobeSyncN) begin
            ready_r <= enable_r;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_r <= fpp_pkg::CTRL_ENABLE_RST;
      rdData_r <= '0;
    end else begin
      if (regWrite && regSelCtrl) begin
        enable_r <= regWrData[fpp_pkg::CTRL_ENABLE];
      end
      rdData_r <= regRead ? regReadMux : 32'h0000_0000;
    end
  end

  assign dataOut      = dout_r;
  assign dataOe_n     = oeN_r;
  assign ready        = ready_r;
  assign data_valid_n = validN_r;
  assign regRdData    = rdData_r;
endmodule
`default_nettype wire

// File: rtl/fpp_pkg.sv
// Constants shared by the parallel flash programming port
package fpp_pkg;
  // Phase selector codes
  localparam logic [3:0] PH_COMMAND = 4'h0;
  localparam logic [3:0] PH_ADDRESS_PHASE_ZERO   = 4'h1;
  localparam logic [3:0] PH_ADDRESS_PHASE_THREE   = 4'h4;
  localparam logic [3:0] PH_DATA    = 4'h5;
  // Command codes
  localparam logic [15:0] CMD_READ             = 16'h0011;
  localparam logic [15:0] CMD_WRITE_PAGE       = 16'h0012;
  localparam logic [15:0] CMD_WRITE_LOCK       = 16'h0022;
  localparam logic [15:0] CMD_ERASE_WRITE      = 16'h0032;
  localparam logic [15:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
  localparam logic [15:0] CMD_RESET            = 16'h0000;
  // Assembled address width
  localparam int ADDR_BITS = 32;
  // Register port offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_COMMAND = 4'h8;
  localparam logic [3:0] REG_ADDRESS = 4'hc;
  // Field positions and reset values
  localparam int   CTRL_ENABLE     = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int   STAT_READY      = 0;
  localparam int   STAT_BUSY       = 1;
  localparam int   STAT_DIRTY      = 2;
  localparam int   STAT_LOCK_LSB   = 16;
  // Flash program time in clock cycles
  localparam int PROG_CYCLES_DEFAULT = 16;
endpackage

// File: rtl/sync_2ff.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int   W       = 1,
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_r <= {W{RST_VAL}};
      syncOut  <= {W{RST_VAL}};
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// File: rtl/flash_page_store.sv
// Flash array with page load buffer, timed flush and lock bits
`timescale 1ns/1ps
`default_nettype none
module flash_page_store #(
  parameter int W            = 16,
  parameter int FLASH_WORDS  = 1024,
  parameter int PAGE_WORDS   = 32,
  parameter int REGION_PAGES = 4,
  parameter int PROG_CYCLES  = fpp_pkg::PROG_CYCLES_DEFAULT,
  localparam int AW      = $clog2(FLASH_WORDS),
  localparam int OW      = $clog2(PAGE_WORDS),
  localparam int PW      = AW - OW,
  localparam int REGIONS = FLASH_WORDS / (PAGE_WORDS * REGION_PAGES)
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Read port
  input  wire logic [AW-1:0]      rdAddr,
  output logic      [W-1:0]       rdData,
  // Load buffer write
  input  wire logic               bufWe,
  input  wire logic [OW-1:0]      bufOffset,
  input  wire logic [W-1:0]       bufData,
  // Flush request
  input  wire logic               flushReq,
  input  wire logic [PW-1:0]      flushPage,
  input  wire logic               flushErase,
  input  wire logic               flushLock,
  // Status
  output logic                    busy,
  output logic                    dirty,
  output logic      [REGIONS-1:0] lockBits
);
  localparam int RB = $clog2(REGION_PAGES);
  localparam int CW = $clog2(PROG_CYCLES + 1);

  logic [W-1:0]          mem [FLASH_WORDS];
  logic [W-1:0]          pageBuf [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] loaded_r;
  logic [CW-1:0]         cnt_r;
  logic [PW-1:0]         page_r;
  logic                  erase_r;
  logic                  lock_r;
  logic                  busy_r;
  logic [REGIONS-1:0]    lock_r_bits;
  wire logic             done       = busy_r && (cnt_r == '0);
  wire logic [PW-RB-1:0] region     = page_r[PW-1:RB];
  wire logic             pageLocked = lock_r_bits[region];

  if (REGIONS < 2 || REGIONS > 16 || PROG_CYCLES < 1) begin : g_bad
    $error("flash_page_store: unsupported geometry");
  end

  assign busy     = busy_r;
  assign dirty    = |loaded_r;
  assign lockBits = lock_r_bits;

  ////////////////////////////////////////////////////////////////////
  // Control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_r      <= 1'b0;
      cnt_r       <= '0;
      page_r      <= '0;
      erase_r     <= 1'b0;
      lock_r      <= 1'b0;
      loaded_r    <= '0;
      lock_r_bits <= '0;
    end else if (flushReq && !busy_r) begin
      busy_r  <= 1'b1;
      cnt_r   <= CW'(PROG_CYCLES - 1);
      page_r  <= flushPage;
      erase_r <= flushErase;
      lock_r  <= flushLock;
    end else if (done) begin
      busy_r   <= 1'b0;
      loaded_r <= '0;
      if (lock_r) begin
        lock_r_bits[region] <= 1'b1;
      end
    end else if (busy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end else if (bufWe) begin
      loaded_r[bufOffset] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Array and buffer
  always_ff @(posedge sys_clk) begin
    rdData <= mem[rdAddr];
    if (bufWe && !busy_r) begin
      pageBuf[bufOffset] <= bufData;
    end
    if (done && !pageLocked) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        if (erase_r) begin
          mem[{page_r, OW'(i)}] <= loaded_r[i] ? pageBuf[i] : {W{1'b1}};
        end else if (loaded_r[i]) begin
          mem[{page_r, OW'(i)}] <= mem[{page_r, OW'(i)}] & pageBuf[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/flash_parallel_program_port_asserts.sv
// Port checker for the parallel flash programming port
`timescale 1ns/1ps
`default_nettype none
module flash_parallel_program_port_asserts #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Pins
  input wire logic              command_strobe_n,
  input wire logic              output_enable_n,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic              dataOe_n,
  input wire logic              ready,
  input wire logic              data_valid_n,
  // Register port
  input wire logic              regRead,
  input wire logic [31:0]       regRdData
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  reset_values_a:
    assert property (disable iff (1'b0) rst |=> !ready && dataOe_n && data_valid_n
      && dataOut == '0 && regRdData == '0) else $error("outputs not at reset values");
  ready_fall_a:
    assert property (ready && !$past(command_strobe_n, 2) |-> ##[1:3] !ready)
      else $error("ready did not drop after strobe");
  ready_hold_a:
    assert property (!ready && !$past(command_strobe_n, 2) |=> !ready)
      else $error("ready rose while strobe low");
  ready_rise_a:
    assert property ($rose(ready) |-> $past(command_strobe_n, 2) && data_valid_n && dataOe_n)
      else $error("ready rose too early");
  oe_respond_a:
    assert property (!ready && !$past(output_enable_n, 2) && dataOe_n && data_valid_n
      |-> ##[1:2] !dataOe_n) else $error("bus not driven after output enable");
  valid_after_drive_a:
    assert property ($fell(data_valid_n) |-> !dataOe_n && $past(!dataOe_n))
      else $error("data valid before bus driven");
  valid_hold_a:
    assert property (!data_valid_n && !$past(output_enable_n, 2) |=> !data_valid_n)
      else $error("data valid dropped early");
  dout_stable_a:
    assert property (!data_valid_n |-> $stable(dataOut)) else $error("read word moved");
  bus_release_a:
    assert property (!dataOe_n && $past(output_enable_n, 2) |=> dataOe_n)
      else $error("bus not released");
  release_order_a:
    assert property ($rose(data_valid_n) |-> dataOe_n && $past(dataOe_n))
      else $error("data valid rose before release");
  rdata_idle_a:
    assert property (!$past(regRead) |-> regRdData == 32'h0)
      else $error("register data outside read cycle");
endmodule
bind flash_parallel_program_port flash_parallel_program_port_asserts #(.DATA_W(DATA_W))
  i_flash_parallel_program_port_asserts (.sys_clk(sys_clk), .rst(rst),
  .command_strobe_n(command_strobe_n), .output_enable_n(output_enable_n), .dataOut(dataOut),
  .dataOe_n(dataOe_n), .ready(ready), .data_valid_n(data_valid_n), .regRead(regRead),
  .regRdData(regRdData));
`default_nettype wire

// File: testbench/fpp_programmer_model.sv
// Gang programmer model driving the handshake pins
`timescale 1ns/1ps
`default_nettype none
module fpp_programmer_model #(
  parameter int W = 16
) (
  // Clock
  input  wire logic         sys_clk,
  // Device answers
  input  wire logic         ready,
  input  wire logic         data_valid_n,
  input  wire logic [W-1:0] busIn,
  // Programmer drives
  output var  logic         command_strobe_n,
  output var  logic         output_enable_n,
  output var  logic [3:0]   phaseSelect,
  output var  logic [W-1:0] busOut,
  output var  logic         busDrive,
  output var  logic         stuck
);
  initial begin
    command_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    phaseSelect = 4'hf;
    busOut = '0;
    busDrive = 1'b0;
    stuck = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bounded wait on ready or data valid
  task automatic wait_for(input logic sel, input logic lvl);
    for (int i = 0; i < 400 && (sel ? data_valid_n : ready) !== lvl; i++)
      @(posedge sys_clk);
    if ((sel ? data_valid_n : ready) !== lvl)
      stuck <= 1'b1;
  endtask
  // One write or read handshake
  task automatic hs(input logic [3:0] ph, input logic [W-1:0] d, input logic rd,
                    output logic [W-1:0] q);
    q = '0;
    wait_for(1'b0, 1'b1);
    @(posedge sys_clk);
    phaseSelect <= ph;
    busOut <= d;
    busDrive <= 1'b1;
    @(posedge sys_clk);
    command_strobe_n <= 1'b0;
    wait_for(1'b0, 1'b0);
    @(posedge sys_clk);
    phaseSelect <= 4'hf;
    busDrive <= 1'b0;
    if (rd) begin
      @(posedge sys_clk);
      output_enable_n <= 1'b0;
      wait_for(1'b1, 1'b0);
      q = busIn;
      @(posedge sys_clk);
      output_enable_n <= 1'b1;
      wait_for(1'b1, 1'b1);
      @(posedge sys_clk);
      busOut <= ~d;
      busDrive <= 1'b1;
    end
    @(posedge sys_clk);
    command_strobe_n <= 1'b1;
    wait_for(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// File: testbench/flash_parallel_program_port_tb_top.sv
// Testbench for the parallel flash programming port
`timescale 1ns/1ps
`default_nettype none
module flash_parallel_program_port_tb_top;
  logic        sys_clk;
  logic        rst;
  logic        command_strobe_n;
  logic        output_enable_n;
  logic [3:0]  phaseSelect;
  logic [15:0] pgmData;
  logic        pgmDrive;
  logic [15:0] dataIn;
  logic [15:0] dataOut;
  logic        dataOe_n;
  logic        ready;
  logic        data_valid_n;
  logic        stuck;
  logic [3:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdData;
  int          num_errors = 0;
  int          checks_done = 0;
  logic        strobe8_n;
  logic        outEn8_n;
  logic [3:0]  phase8;
  logic [7:0]  pgmData8;
  logic        pgmDrive8;
  logic [7:0]  dataIn8;
  logic [7:0]  dataOut8;
  logic        busOe8_n;
  logic        ready8;
  logic        valid8_n;
  logic        stuck8;

  // Bus level with pull-ups
  assign dataIn = pgmDrive ? pgmData : (!dataOe_n ? dataOut : 16'hffff);
  assign dataIn8 = pgmDrive8 ? pgmData8 : (!busOe8_n ? dataOut8 : 8'hff);

  flash_parallel_program_port #(.DATA_W(16), .PROG_CYCLES(4)) i_flash_parallel_program_port (
    .sys_clk(sys_clk), .rst(rst), .command_strobe_n(command_strobe_n),
    .output_enable_n(output_enable_n), .phaseSelect(phaseSelect), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .ready(ready), .data_valid_n(data_valid_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData));
  fpp_programmer_model #(.W(16)) i_fpp_programmer_model (
    .sys_clk(sys_clk), .ready(ready), .data_valid_n(data_valid_n), .busIn(dataIn),
    .command_strobe_n(command_strobe_n), .output_enable_n(output_enable_n),
    .phaseSelect(phaseSelect), .busOut(pgmData), .busDrive(pgmDrive), .stuck(stuck));
  // Eight-bit bus variant
  flash_parallel_program_port #(.DATA_W(8), .PROG_CYCLES(4)) i_flash_parallel_program_port_8 (
    .sys_clk(sys_clk), .rst(rst), .command_strobe_n(strobe8_n),
    .output_enable_n(outEn8_n), .phaseSelect(phase8), .dataIn(dataIn8),
    .dataOut(dataOut8), .dataOe_n(busOe8_n), .ready(ready8), .data_valid_n(valid8_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData());
  fpp_programmer_model #(.W(8)) i_fpp_programmer_model_8 (
    .sys_clk(sys_clk), .ready(ready8), .data_valid_n(valid8_n), .busIn(dataIn8),
    .command_strobe_n(strobe8_n), .output_enable_n(outEn8_n),
    .phaseSelect(phase8), .busOut(pgmData8), .busDrive(pgmDrive8), .stuck(stuck8));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and compares
  task automatic test_done();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t value %h exp %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Register port and pin sequences
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask
  task automatic hw(input logic [3:0] ph, input logic [15:0] d);
    logic [15:0] q;
    i_fpp_programmer_model.hs(ph, d, 1'b0, q);
  endtask
  task automatic ld_addr(input logic [15:0] a);
    hw(fpp_pkg::PH_ADDRESS_PHASE_ZERO, a);
    hw(fpp_pkg::PH_ADDRESS_PHASE_ZERO + 4'h1, 16'h0000);
  endtask
  task automatic wr_words(input logic [15:0] cmd, input logic [15:0] a, input int n,
                          input logic [15:0] d0);
    hw(fpp_pkg::PH_COMMAND, cmd);
    ld_addr(a);
    for (int i = 0; i < n; i++)
      hw(fpp_pkg::PH_DATA, d0 + 16'(i));
  endtask
  task automatic rd_words(input logic ld, input logic [15:0] a, input int n,
                          input logic [15:0] d0);
    logic [15:0] q;
    if (ld)
      ld_addr(a);
    for (int i = 0; i < n; i++) begin
      i_fpp_programmer_model.hs(fpp_pkg::PH_DATA, 16'h0000, 1'b1, q);
      cmp_word(q, d0 + 16'(i));
    end
  endtask
  task automatic hs8(input logic [3:0] ph, input logic [7:0] d, input logic rd,
                     output logic [7:0] q);
    i_fpp_programmer_model_8.hs(ph, d, rd, q);
  endtask
  task automatic ld_addr8(input logic [31:0] a);
    logic [7:0] q;
    for (int i = 0; i < 4; i++)
      hs8(fpp_pkg::PH_ADDRESS_PHASE_ZERO + 4'(i), 8'(a >> (8 * i)), 1'b0, q);
  endtask
  task automatic rd_words8(input logic [31:0] a, input int n, input logic [7:0] d0);
    logic [7:0] q;
    ld_addr8(a);
    for (int i = 0; i < n; i++) begin
      hs8(fpp_pkg::PH_DATA, 8'h00, 1'b1, q);
      cmp_word({8'h00, q}, {8'h00, d0 + 8'(i)});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    logic [31:0] r;
    logic [7:0]  q8;
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (16) @(posedge sys_clk);
    cmp_reg({31'h0, ready}, 32'h0);
    rst <= 1'b0;
    reg_rd(fpp_pkg::REG_CTRL, r);
    cmp_reg(r, 32'h1);
    reg_rd(4'h2, r);
    cmp_reg(r, 32'h0);
    reg_wr(fpp_pkg::REG_CTRL, 32'h0);
    repeat (4) @(posedge sys_clk);
    cmp_reg({31'h0, ready}, 32'h0);
    reg_wr(fpp_pkg::REG_CTRL, 32'h1);
    wr_words(fpp_pkg::CMD_ERASE_WRITE, 16'h0040, 3, 16'h1110);
    reg_rd(fpp_pkg::REG_STATUS, r);
    cmp_reg(r & 32'h4, 32'h4);
    hw(fpp_pkg::PH_COMMAND, fpp_pkg::CMD_READ);
    rd_words(1'b1, 16'h0040, 2, 16'h1110);
    hw(4'h6, 16'h0000);
    hw(4'h3, 16'h0001);
    rd_words(1'b0, 16'h0042, 1, 16'h1112);
    rd_words(1'b1, 16'h0043, 1, 16'hffff);
    wr_words(fpp_pkg::CMD_WRITE_PAGE, 16'h0043, 1, 16'h1234);
    wr_words(fpp_pkg::CMD_ERASE_WRITE, 16'h009f, 2, 16'h2000);
    wr_words(fpp_pkg::CMD_ERASE_WRITE_LOCK, 16'h0060, 1, 16'h3000);
    wr_words(fpp_pkg::CMD_ERASE_WRITE, 16'h00e0, 1, 16'h5000);
    wr_words(fpp_pkg::CMD_WRITE_LOCK, 16'h00e0, 1, 16'h5000);
    hw(fpp_pkg::PH_COMMAND, fpp_pkg::CMD_READ);
    reg_rd(fpp_pkg::REG_STATUS, r);
    cmp_reg(r & 32'h00ff0004, 32'h00030000);
    rd_words(1'b1, 16'h0043, 1, 16'h1234);
    rd_words(1'b1, 16'h009f, 2, 16'h2000);
    rd_words(1'b1, 16'h0060, 1, 16'h3000);
    rd_words(1'b1, 16'h00e0, 1, 16'h5000);
    wr_words(fpp_pkg::CMD_WRITE_PAGE, 16'h0060, 1, 16'h0000);
    hw(fpp_pkg::PH_COMMAND, fpp_pkg::CMD_READ);
    rd_words(1'b1, 16'h0060, 1, 16'h3000);
    reg_rd(fpp_pkg::REG_COMMAND, r);
    cmp_reg(r, {16'h0000, fpp_pkg::CMD_READ});
    cmp_reg({31'h0, stuck}, 32'h0);
    hs8(fpp_pkg::PH_COMMAND, 8'(fpp_pkg::CMD_ERASE_WRITE), 1'b0, q8);
    ld_addr8(32'h0000_0125);
    hs8(fpp_pkg::PH_DATA, 8'ha5, 1'b0, q8);
    hs8(fpp_pkg::PH_DATA, 8'ha6, 1'b0, q8);
    hs8(fpp_pkg::PH_COMMAND, 8'(fpp_pkg::CMD_READ), 1'b0, q8);
    rd_words8(32'h0000_0125, 2, 8'ha5);
    rd_words8(32'h0000_0127, 1, 8'hff);
    cmp_reg({31'h0, stuck8}, 32'h0);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
